// ==== dbpg_buck.sv ====
/*
 * one converter's mode controller: pwm/pulse-mode selection, pulse
 * sequencing, shutdown and soft-start limit stepping. assumes the
 * comparator inputs are synchronous to clk.
 */
`timescale 1ns/1ps
module dbpg_buck #(
   parameter int unsigned ENTRY_CYCLES = dbpg_pkg::PFM_ENTRY_CYCLES,
   parameter int unsigned STEP_CYCLES = dbpg_pkg::SS_STEP_CYCLES
) (
   input wire logic clk, // oscillator clock
   input wire logic rst_b, // async reset, active low
   input wire logic en, // gated converter enable
   input wire logic force_pwm, // option: always pwm
   input wire logic discont, // inductor current discontinuous
   input wire logic peak_low, // peak current below mode threshold
   input wire logic above_hi, // output above high pulse threshold
   input wire logic below_lo, // output below low pulse threshold
   input wire logic below_lo2, // output below second low threshold
   input wire logic peak_limit, // pulse-mode peak limit reached
   input wire logic zero_cur, // zero-current detected
   output logic hs_on, // high-side switch
   output logic ls_on, // low-side switch
   output logic bias_on, // reference, control and bias
   output logic pfm_mode, // pulse mode active
   output logic [1:0] ilim_step // soft-start limit step
);
   typedef struct packed {
      dbpg_pkg::dbpg_mode_e st;
      logic [5:0] ent_cnt;
      logic [8:0] ss_cnt;
      logic [1:0] ilim;
      logic hs;
      logic ls;
      logic bias;
      logic pfm;
   } dbpg_buck_s;

   dbpg_buck_s s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.hs = 1'b0;
      s_d.ls = 1'b0;
      s_d.bias = 1'b1;
      case (s_q.st)
         dbpg_pkg::ST_OFF: begin
            s_d.ls = 1'b1;
            s_d.bias = 1'b0;
            s_d.ilim = dbpg_pkg::ILIM_250MA;
            s_d.ss_cnt = '0;
            s_d.ent_cnt = '0;
            if (en) begin
               s_d.st = dbpg_pkg::ST_PWM;
            end
         end
         dbpg_pkg::ST_PWM: begin
            if ((discont || peak_low) && !force_pwm) begin
               if (s_q.ent_cnt == 6'(ENTRY_CYCLES - 1)) begin
                  s_d.st = dbpg_pkg::ST_SLEEP;
                  s_d.ent_cnt = '0;
               end else begin
                  s_d.ent_cnt = s_q.ent_cnt + 6'h01;
               end
            end else begin
               s_d.ent_cnt = '0;
            end
         end
         dbpg_pkg::ST_HI_ON: begin
            s_d.hs = 1'b1;
            if (above_hi || peak_limit) begin
               s_d.hs = 1'b0;
               s_d.ls = 1'b1;
               s_d.st = dbpg_pkg::ST_LO_ON;
            end
         end
         dbpg_pkg::ST_LO_ON: begin
            s_d.ls = 1'b1;
            if (zero_cur) begin
               s_d.ls = 1'b0;
               s_d.st = above_hi ? dbpg_pkg::ST_ZERO
                  : dbpg_pkg::ST_HI_ON;
               s_d.ls = above_hi;
               s_d.hs = !above_hi;
            end
         end
         dbpg_pkg::ST_ZERO: begin
            // brief low-side pulse to drain residual current
            s_d.st = dbpg_pkg::ST_SLEEP;
         end
         dbpg_pkg::ST_SLEEP: begin
            s_d.bias = 1'b0;
            if (below_lo) begin
               s_d.st = dbpg_pkg::ST_HI_ON;
               s_d.hs = 1'b1;
               s_d.bias = 1'b1;
            end
         end
         default: s_d.st = dbpg_pkg::ST_OFF;
      endcase
      // pulse band above nominal is set by the comparator trims
      if (s_q.st != dbpg_pkg::ST_OFF && s_q.st != dbpg_pkg::ST_PWM &&
          (below_lo2 || force_pwm)) begin
         s_d.st = dbpg_pkg::ST_PWM;
         s_d.hs = 1'b0;
         s_d.ls = 1'b0;
         s_d.bias = 1'b1;
      end
      if (s_q.st != dbpg_pkg::ST_OFF && s_q.ilim != dbpg_pkg::ILIM_2A) begin
         if (s_q.ss_cnt == 9'(STEP_CYCLES - 1)) begin
            s_d.ss_cnt = '0;
            s_d.ilim = s_q.ilim + 2'h1;
         end else begin
            s_d.ss_cnt = s_q.ss_cnt + 9'h001;
         end
      end
      if (!en) begin
         s_d.st = dbpg_pkg::ST_OFF;
         s_d.hs = 1'b0;
         s_d.ls = 1'b1;
         s_d.bias = 1'b0;
         s_d.ilim = dbpg_pkg::ILIM_250MA;
      end
      s_d.pfm = (s_d.st != dbpg_pkg::ST_OFF) && (s_d.st != dbpg_pkg::ST_PWM);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '{st: dbpg_pkg::ST_OFF, ent_cnt: 6'h00, ss_cnt: 9'h000,
                  ilim: dbpg_pkg::ILIM_250MA, hs: 1'b0, ls: 1'b1,
                  bias: 1'b0, pfm: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign hs_on = s_q.hs;
   assign ls_on = s_q.ls;
   assign bias_on = s_q.bias;
   assign pfm_mode = s_q.pfm;
   assign ilim_step = s_q.ilim;

   a_no_shoot: assert property (@(posedge clk) disable iff (!rst_b)
      !(s_q.hs && s_q.ls))
      else $error("both switches on");
   a_off_discharge: assert property (@(posedge clk) disable iff (!rst_b)
      $past(!en) |-> (s_q.ls && !s_q.hs && !s_q.bias))
      else $error("disabled converter not discharging");
   a_forced_pwm: assert property (@(posedge clk) disable iff (!rst_b)
      $past(force_pwm) |-> !s_q.pfm)
      else $error("pulse mode while pwm forced");
   a_pfm_entry: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(s_q.pfm) && $past(s_q.st) == dbpg_pkg::ST_PWM
      |-> $past(discont || peak_low, 32))
      else $error("pulse mode entered too early");
   a_low2_exit: assert property (@(posedge clk) disable iff (!rst_b)
      s_q.pfm && below_lo2 && en |=> !s_q.pfm)
      else $error("no return to pwm below low2");

   sequence s_zero_pulse;
      s_q.st == dbpg_pkg::ST_ZERO && s_q.ls && en && !below_lo2 &&
      !force_pwm;
   endsequence
   a_zero_sleep: assert property (@(posedge clk) disable iff (!rst_b)
      s_zero_pulse |=> (s_q.st == dbpg_pkg::ST_SLEEP) && !s_q.ls)
      else $error("no sleep after zero-current pulse");
endmodule : dbpg_buck

// ==== dbpg_host_model.sv ====
/*
 * host side model: the two enable drivers and the pulled-up reset net
 * seen by the system processor. assumes the design only pulls the net
 * low and releases it otherwise.
 */
`timescale 1ns/1ps
module dbpg_host_model (
   input wire logic en1_req, // bench request, converter 1
   input wire logic en2_req, // bench request, converter 2
   input wire logic pin_o, // design drive value
   input wire logic pin_oe, // design drive enable
   output logic en1, // first converter enable
   output logic en2, // second converter enable
   output logic reset_pin // processor reset net
);
   // each enable has a line of its own, never derived from the other
   assign en1 = en1_req;
   assign en2 = en2_req;
   // a released net shows the pull-up level, never a stale drive value
   assign reset_pin = pin_oe ? pin_o : 1'b1;
endmodule : dbpg_host_model

// ==== dbpg_pkg.sv ====
/*
 * constants, encodings and timing figures for the dual buck mode and
 * power-good controller. assumes a 40 MHz internal oscillator clock.
 */
package dbpg_pkg;
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned PFM_ENTRY_CYCLES = 32;
   localparam int unsigned DLY_130US_NS = 130000;
   localparam int unsigned DLY_60MS_MS = 60;
   localparam int unsigned DLY_100MS_MS = 100;
   localparam int unsigned DLY_200MS_MS = 200;
   localparam int unsigned MASK_MS = 5;
   localparam int unsigned CYC_130US =
      (DLY_130US_NS / 1000) * (CLK_HZ / 1000000);
   localparam int unsigned CYC_60MS = DLY_60MS_MS * (CLK_HZ / 1000);
   localparam int unsigned CYC_100MS = DLY_100MS_MS * (CLK_HZ / 1000);
   localparam int unsigned CYC_200MS = DLY_200MS_MS * (CLK_HZ / 1000);
   localparam int unsigned CYC_MASK = MASK_MS * (CLK_HZ / 1000);
   localparam int unsigned SS_STEP_CYCLES = 256;
   localparam int unsigned CNT_W = 24;
   // delay select codes
   localparam logic [1:0] SEL_130US = 2'h0;
   localparam logic [1:0] SEL_60MS = 2'h1;
   localparam logic [1:0] SEL_100MS = 2'h2;
   localparam logic [1:0] SEL_200MS = 2'h3;
   localparam logic [1:0] SEL_DEFAULT = SEL_60MS;
   // soft-start current limit step codes (mA: 250, 500, 950, 2000)
   localparam logic [1:0] ILIM_250MA = 2'h0;
   localparam logic [1:0] ILIM_500MA = 2'h1;
   localparam logic [1:0] ILIM_950MA = 2'h2;
   localparam logic [1:0] ILIM_2A = 2'h3;
   typedef enum logic [2:0] {
      ST_OFF = 3'h0,
      ST_PWM = 3'h1,
      ST_HI_ON = 3'h2,
      ST_LO_ON = 3'h3,
      ST_ZERO = 3'h4,
      ST_SLEEP = 3'h5
   } dbpg_mode_e;
endpackage : dbpg_pkg

// ==== dbpg_top.sv ====
/*
 * dual buck controller with power-good supervisor, undervoltage gating
 * and delay/mask timers. assumes all inputs are synchronous to clk and
 * the supply-ok comparator already carries its own hysteresis.
 */
`timescale 1ns/1ps
module dbpg_top #(
   parameter int unsigned DLY_130US = dbpg_pkg::CYC_130US,
   parameter int unsigned DLY_60MS = dbpg_pkg::CYC_60MS,
   parameter int unsigned DLY_100MS = dbpg_pkg::CYC_100MS,
   parameter int unsigned DLY_200MS = dbpg_pkg::CYC_200MS,
   parameter int unsigned MASK_CYC = dbpg_pkg::CYC_MASK,
   parameter int unsigned SS_STEP = dbpg_pkg::SS_STEP_CYCLES
) (
   input wire logic clk, // oscillator clock
   input wire logic rst_b, // internal power-on reset, active low
   input wire logic monitored_core_supply, // supply above 2.8 v, hyst.
   input wire logic first_converter_enable, // enable of converter 1
   input wire logic second_converter_enable, // enable of converter 2
   input wire logic ldo1_enable_in, // first ldo enable request
   input wire logic ldo2_enable_in, // second ldo enable request
   input wire logic first_output_level_ok, // converter 1 output ok
   input wire logic second_output_level_ok, // converter 2 output ok
   input wire logic [1:0] delay_sel, // release delay option
   input wire logic force_pwm, // factory option: pwm only
   input wire logic [1:0] discont, // per converter discontinuous
   input wire logic [1:0] peak_low, // peak below mode threshold
   input wire logic [1:0] above_hi, // above high pulse threshold
   input wire logic [1:0] below_lo, // below low pulse threshold
   input wire logic [1:0] below_lo2, // below second low threshold
   input wire logic [1:0] pulse_mode_peak_current_limit, // peak limit hit
   input wire logic [1:0] zero_cur, // zero-current detected
   output logic [1:0] hs_on, // high-side switches
   output logic [1:0] ls_on, // low-side switches
   output logic [1:0] bias_on, // converter bias
   output logic [1:0] pfm_mode, // pulse mode flags
   output logic [3:0] ilim_step, // two soft-start limit codes
   output logic [1:0] ldo_en, // gated ldo enables
   output logic power_good_reset_n_o, // reset pin driven value
   output logic power_good_reset_n_oe // reset pin drive enable
);
   typedef struct packed {
      logic [3:0] en_gate;
      logic [1:0] en_prev;
      logic [1:0] ok_prev;
      logic done;
      logic running;
      logic [dbpg_pkg::CNT_W-1:0] dly_cnt;
      logic [1:0] mask_on;
      logic [dbpg_pkg::CNT_W-1:0] mask_cnt0;
      logic [dbpg_pkg::CNT_W-1:0] mask_cnt1;
      logic drive_low;
   } dbpg_top_s;

   dbpg_top_s s_q, s_d;
   logic [1:0] en_raw, ok;
   logic [dbpg_pkg::CNT_W-1:0] dly_term;

   function automatic logic [dbpg_pkg::CNT_W-1:0] sel_term(
      input logic [1:0] sel);
      case (sel)
         dbpg_pkg::SEL_130US: sel_term = dbpg_pkg::CNT_W'(DLY_130US - 1);
         dbpg_pkg::SEL_60MS: sel_term = dbpg_pkg::CNT_W'(DLY_60MS - 1);
         dbpg_pkg::SEL_100MS: sel_term = dbpg_pkg::CNT_W'(DLY_100MS - 1);
         default: sel_term = dbpg_pkg::CNT_W'(DLY_200MS - 1);
      endcase
   endfunction : sel_term

   assign en_raw = {second_converter_enable, first_converter_enable};
   assign ok = {second_output_level_ok, first_output_level_ok};
   assign dly_term = sel_term(delay_sel);

   always_comb begin
      logic [1:0] en_g, en_rise, ok_rise, ok_fall, mask_out;
      logic set_t, rst_t;
      en_g = '0;
      en_rise = '0;
      ok_rise = '0;
      ok_fall = '0;
      mask_out = '0;
      set_t = 1'b0;
      rst_t = 1'b0;
      s_d = s_q;
      // lockout gates all four regulator enables
      s_d.en_gate = monitored_core_supply ?
         {ldo2_enable_in, ldo1_enable_in, en_raw} : 4'h0;
      en_g = s_q.en_gate[1:0];
      en_rise = en_g & ~s_q.en_prev;
      ok_rise = ok & ~s_q.ok_prev & en_g;
      ok_fall = ~ok & s_q.ok_prev;
      s_d.en_prev = en_g;
      s_d.ok_prev = ok;
      // reset when no converter enabled; set wins only when no reset
      rst_t = (en_g == 2'h0);
      set_t = !rst_t && (|ok_rise) && !s_q.running && !s_q.done;
      if (rst_t) begin
         s_d.running = 1'b0;
         s_d.done = 1'b0;
         s_d.dly_cnt = '0;
      end else if (s_q.done && (|(ok_fall & en_g & ~s_q.mask_on))) begin
         s_d.done = 1'b0;
         s_d.running = 1'b1;
         s_d.dly_cnt = '0;
      end else if (set_t) begin
         s_d.running = 1'b1;
         s_d.dly_cnt = '0;
      end else if (s_q.running) begin
         // other converter activity is not looked at here
         if (s_q.dly_cnt >= dly_term) begin
            s_d.running = 1'b0;
            s_d.done = 1'b1;
         end else begin
            s_d.dly_cnt = s_q.dly_cnt + dbpg_pkg::CNT_W'(1);
         end
      end
      // mask timers on enable rises after the delay completed
      if (s_q.mask_on[0]) begin
         if (s_q.mask_cnt0 >= dbpg_pkg::CNT_W'(MASK_CYC - 1)) begin
            s_d.mask_on[0] = 1'b0;
         end else begin
            s_d.mask_cnt0 = s_q.mask_cnt0 + dbpg_pkg::CNT_W'(1);
         end
      end
      if (s_q.mask_on[1]) begin
         if (s_q.mask_cnt1 >= dbpg_pkg::CNT_W'(MASK_CYC - 1)) begin
            s_d.mask_on[1] = 1'b0;
         end else begin
            s_d.mask_cnt1 = s_q.mask_cnt1 + dbpg_pkg::CNT_W'(1);
         end
      end
      if (s_q.done && en_rise[0]) begin
         s_d.mask_on[0] = 1'b1;
         s_d.mask_cnt0 = '0;
      end
      if (s_q.done && en_rise[1]) begin
         s_d.mask_on[1] = 1'b1;
         s_d.mask_cnt1 = '0;
      end
      if (!en_g[0]) begin
         s_d.mask_on[0] = 1'b0;
      end
      if (!en_g[1]) begin
         s_d.mask_on[1] = 1'b0;
      end
      // a disabled converter does not pull the reset down
      // a late enable already counts as masked in its own rise cycle,
      // otherwise the pin would dip low for one cycle
      mask_out = s_d.mask_on | ok | ~en_g;
      // kept as the pin drive itself so the output leaves a flop
      s_d.drive_low = rst_t || !s_q.done || !(&mask_out) ||
         (|(ok_fall & en_g & ~s_q.mask_on));
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '{drive_low: 1'b1, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_buck
         dbpg_buck #(
            .ENTRY_CYCLES(dbpg_pkg::PFM_ENTRY_CYCLES),
            .STEP_CYCLES(SS_STEP)
         ) u_buck (
            .clk(clk),
            .rst_b(rst_b),
            .en(s_q.en_gate[gi]),
            .force_pwm(force_pwm),
            .discont(discont[gi]),
            .peak_low(peak_low[gi]),
            .above_hi(above_hi[gi]),
            .below_lo(below_lo[gi]),
            .below_lo2(below_lo2[gi]),
            .peak_limit(pulse_mode_peak_current_limit[gi]),
            .zero_cur(zero_cur[gi]),
            .hs_on(hs_on[gi]),
            .ls_on(ls_on[gi]),
            .bias_on(bias_on[gi]),
            .pfm_mode(pfm_mode[gi]),
            .ilim_step(ilim_step[2*gi+1:2*gi])
         );
      end
   endgenerate

   // open drain: only ever drives low, released pin floats high
   assign power_good_reset_n_o = 1'b0;
   assign power_good_reset_n_oe = s_q.drive_low;
   assign ldo_en = s_q.en_gate[3:2];

   a_uvlo_gate: assert property (@(posedge clk) disable iff (!rst_b)
      !monitored_core_supply |=> s_q.en_gate == 4'h0)
      else $error("enable passed during lockout");
   a_pg_needs_done: assert property (@(posedge clk) disable iff (!rst_b)
      !s_q.drive_low |-> s_q.done)
      else $error("power good before delay done");
   a_no_en_low: assert property (@(posedge clk) disable iff (!rst_b)
      s_q.en_gate[1:0] == 2'h0 |=> s_q.drive_low && !s_q.running)
      else $error("timer not reset without enables");
   a_fall_low: assert property (@(posedge clk) disable iff (!rst_b)
      s_q.done && s_q.en_gate[0] && !s_q.mask_on[0] &&
      s_q.ok_prev[0] && !first_output_level_ok && s_q.en_gate[1:0] != 2'h0
      |=> s_q.drive_low && s_q.running)
      else $error("level fall did not restart delay");

   sequence s_late_rise;
      s_q.done && !s_q.drive_low && s_q.en_gate[1] && !s_q.en_prev[1];
   endsequence
   sequence s_others_quiet;
      (first_output_level_ok || !s_q.en_gate[0]) &&
      !(s_q.ok_prev[1] && !second_output_level_ok);
   endsequence
   a_mask_holds_high: assert property (@(posedge clk) disable iff (!rst_b)
      s_late_rise and s_others_quiet |=> !s_q.drive_low)
      else $error("reset pin dipped at masked enable rise");
endmodule : dbpg_top

// ==== tb_top.sv ====
/*
 * self-checking bench for the dual buck controller: power-good timing,
 * mask window, lockout, soft start and pulse-mode sequencing.
 * assumes short timer parameters and the host model for the reset net.
 */
`timescale 1ns/1ps
module tb_top;
   localparam int MASK = 30;
   localparam int LIMIT = 6000;
   localparam int TERM [4] = '{20, 40, 60, 80};
   typedef struct {logic v; int lo; int hi;} dbpg_pin_exp_s;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic supply_ok = 1'b1;
   logic en1_req = 1'b0;
   logic en2_req = 1'b0;
   logic [1:0] ldo_req = 2'h0;
   logic ok1 = 1'b0;
   logic ok2 = 1'b0;
   logic [1:0] dsel = 2'h1;
   logic fpwm = 1'b0;
   logic [1:0] discont = 2'h0;
   logic [1:0] peak_low = 2'h0;
   logic [1:0] above_hi = 2'h3;
   logic [1:0] below_lo = 2'h0;
   logic [1:0] below_lo2 = 2'h0;
   logic [1:0] peak_lim = 2'h0;
   logic [1:0] zero_cur = 2'h0;
   logic [1:0] hs_on, ls_on, bias_on, pfm_mode, ldo_en;
   logic [3:0] ilim_step;
   logic pg_o, pg_oe, en1, en2, reset_pin;
   logic pin_prev = 1'b0;
   int cyc = 0;
   int error_cnt = 0;
   int num_checks = 0;
   dbpg_pin_exp_s pin_q [$];
   string nm [7] = '{"switches", "ilim", "ldo_en", "pfm_mode", "bias",
      "switches2", "ilim2"};

   dbpg_top #(.DLY_130US(20), .DLY_60MS(40), .DLY_100MS(60),
      .DLY_200MS(80), .MASK_CYC(MASK), .SS_STEP(4)) dbpg_top_i (
      .clk(clk), .rst_b(rst_b), .monitored_core_supply(supply_ok),
      .first_converter_enable(en1), .second_converter_enable(en2),
      .ldo1_enable_in(ldo_req[0]), .ldo2_enable_in(ldo_req[1]),
      .first_output_level_ok(ok1), .second_output_level_ok(ok2),
      .delay_sel(dsel), .force_pwm(fpwm), .discont(discont),
      .peak_low(peak_low), .above_hi(above_hi), .below_lo(below_lo),
      .below_lo2(below_lo2), .pulse_mode_peak_current_limit(peak_lim),
      .zero_cur(zero_cur), .hs_on(hs_on), .ls_on(ls_on),
      .bias_on(bias_on), .pfm_mode(pfm_mode), .ilim_step(ilim_step),
      .ldo_en(ldo_en), .power_good_reset_n_o(pg_o),
      .power_good_reset_n_oe(pg_oe));
   dbpg_host_model dbpg_host_model_i (.en1_req(en1_req),
      .en2_req(en2_req), .pin_o(pg_o), .pin_oe(pg_oe), .en1(en1),
      .en2(en2), .reset_pin(reset_pin));

   always #12.5 clk = ~clk;

   task automatic report_and_stop();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   task automatic check_pin(input dbpg_pin_exp_s e, input logic v);
      num_checks++;
      if (v !== e.v || cyc < e.lo || cyc > e.hi) begin
         error_cnt++;
         $display("MISMATCH reset_pin expected %b in %0d..%0d seen %b at %0d",
            e.v, e.lo, e.hi, v, cyc);
      end
   endtask : check_pin

   task automatic push_pin(input logic v, input int lo, input int hi);
      pin_q.push_back('{v, cyc + lo, cyc + hi});
   endtask : push_pin

   function automatic logic [3:0] obs(input int k);
      case (k)
         0: obs = {1'b0, pfm_mode[0], hs_on[0], ls_on[0]};
         1: obs = {2'h0, ilim_step[1:0]};
         2: obs = {2'h0, ldo_en};
         3: obs = {3'h0, pfm_mode[0]};
         5: obs = {pfm_mode[1], hs_on[1], ls_on[1], bias_on[1]};
         6: obs = {2'h0, ilim_step[3:2]};
         default: obs = {3'h0, bias_on[0]};
      endcase
   endfunction : obs

   // hold: value must stay for n cycles; else it must show within n
   task automatic check_out(input int k, input logic [3:0] e,
      input int n, input bit hold);
      logic [3:0] g;
      int i;
      num_checks++;
      for (i = 0; i < n; i++) begin
         @(negedge clk);
         g = obs(k);
         if (hold ? g !== e : g === e) break;
      end
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm[k], e, g);
      end
   endtask : check_out

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick

   // the scoreboard side: every change of the net takes the oldest note
   always @(posedge clk) begin
      cyc <= cyc + 1;
      pin_prev <= reset_pin;
      if (rst_b && reset_pin !== pin_prev) begin
         if (pin_q.size() == 0) pin_q.push_back('{~reset_pin, 0, 0});
         check_pin(pin_q.pop_front(), reset_pin);
      end
      if (cyc == LIMIT) begin
         error_cnt++;
         report_and_stop();
      end
   end

   initial begin
      int s;
      int i;
      logic r;
      void'($urandom(96893));
      tick(3);
      check_out(5, 4'h2, 1, 1'b1);
      check_out(0, 4'h1, 1, 1'b1);
      rst_b = 1'b1;
      tick(2);
      for (s = 0; s < 4; s++) begin
         dsel = s[1:0];
         en1_req = 1'b1;
         tick(2 + $urandom_range(3));
         push_pin(1'b1, TERM[s], TERM[s] + 8);
         ok1 = 1'b1;
         tick(3);
         en2_req = 1'b1;
         tick(1);
         ok2 = 1'b1;
         tick(1);
         check_out(5, 4'h1, TERM[s] + 8, 1'b1);
         check_out(6, 4'h3, 1, 1'b1);
         push_pin(1'b0, 1, 5);
         ok2 = 1'b0;
         tick(3);
         push_pin(1'b1, TERM[s] - 3, TERM[s] + 8);
         ok2 = 1'b1;
         tick(TERM[s] + 12);
         push_pin(1'b0, 1, 5);
         {en1_req, en2_req, ok1, ok2} = 4'h0;
         tick(6);
      end
      // late second enable with its output never good: mask, then low
      dsel = 2'h0;
      en1_req = 1'b1;
      tick(2);
      push_pin(1'b1, TERM[0], TERM[0] + 8);
      ok1 = 1'b1;
      tick(TERM[0] + 10);
      push_pin(1'b0, MASK, MASK + 8);
      en2_req = 1'b1;
      tick(MASK + 12);
      {en1_req, en2_req, ok1} = 3'h0;
      tick(4);
      supply_ok = 1'b0;
      ldo_req = 2'h3;
      en1_req = 1'b1;
      check_out(2, 4'h0, 6, 1'b1);
      check_out(0, 4'h1, 1, 1'b1);
      supply_ok = 1'b1;
      check_out(1, 4'h0, 3, 1'b1);
      for (i = 1; i < 4; i++) check_out(1, i[3:0], 10, 1'b0);
      check_out(2, 4'h3, 4, 1'b0);
      fpwm = 1'b1;
      discont[0] = 1'b1;
      check_out(3, 4'h0, 50, 1'b1);
      fpwm = 1'b0;
      discont[0] = 1'b0;
      tick(2);
      r = $urandom_range(1);
      {discont[0], peak_low[0]} = {r, ~r};
      check_out(3, 4'h0, 30, 1'b1);
      check_out(3, 4'h1, 8, 1'b0);
      {discont[0], peak_low[0]} = 2'h0;
      check_out(0, 4'h4, 6, 1'b0);
      above_hi[0] = 1'b0;
      check_out(0, 4'h4, 4, 1'b1);
      below_lo[0] = 1'b1;
      check_out(0, 4'h6, 4, 1'b0);
      below_lo[0] = 1'b0;
      check_out(0, 4'h6, 5, 1'b1);
      peak_lim[0] = 1'b1;
      check_out(0, 4'h5, 4, 1'b0);
      peak_lim[0] = 1'b0;
      check_out(0, 4'h5, 4, 1'b1);
      zero_cur[0] = 1'b1;
      check_out(0, 4'h6, 4, 1'b0);
      zero_cur[0] = 1'b0;
      above_hi[0] = 1'b1;
      check_out(0, 4'h5, 4, 1'b0);
      zero_cur[0] = 1'b1;
      check_out(0, 4'h4, 5, 1'b0);
      {zero_cur[0], above_hi[0], below_lo[0]} = 3'h1;
      check_out(0, 4'h6, 4, 1'b0);
      below_lo2[0] = 1'b1;
      check_out(3, 4'h0, 4, 1'b0);
      {below_lo2[0], below_lo[0]} = 2'h0;
      en1_req = 1'b0;
      check_out(0, 4'h1, 5, 1'b0);
      check_out(4, 4'h0, 1, 1'b1);
      tick(5);
      if (pin_q.size() != 0) begin
         error_cnt++;
         $display("MISMATCH reset_pin expected %0d changes seen 0",
            pin_q.size());
      end
      report_and_stop();
   end
endmodule : tb_top
